// [rtl/m8x_defs.vh]
// constants for the 8-bit core execute block
//
// Contract
// [RULE1] load writes constant or register, flags kept
// [RULE2] load reg_zero from itself is two-cycle nop
// [RULE3] and with register or constant, flags updated
// [RULE4] or with register or constant, flags updated
// [RULE5] or with zero clears carry, tests zero
// [RULE6] xor updates zero, forces carry clear
// [RULE7] add stores 8-bit sum, flags updated
// [RULE8] add_with_carry adds carry flag too
// [RULE9] subtract stores 8-bit difference, flags updated
// [RULE10] subtract_with_borrow also subtracts carry flag
// [RULE11] input presents port address, loads data, flags kept
// [RULE12] outside logic decodes address, returns data
// [RULE13] read strobe pulses when a port is read
// [RULE14] output drives register data and port address
// [RULE15] write strobe pulses; outside captures only then
// [RULE16] interrupt_return reloads pc from stack, no increment
// [RULE17] interrupt_return restores saved zero and carry
// [RULE18] interrupt_return operand sets interrupt enable
// [RULE19] enable and disable instructions set/clear enable
// [RULE20] every instruction takes exactly two cycles
// [RULE21] interrupt calls address ff, saves flags, disables
// [RULE22] carry on carry-out or borrow; zero on zero
// [RULE23] and/or clear carry, zero on zero result
`ifndef M8X_DEFS_VH
`define M8X_DEFS_VH

// ----------------------------------------------------------------
// opcode field, instruction bits 15..11
// ----------------------------------------------------------------
`define M8X_OP_HI        15
`define M8X_OP_LO        11
`define M8X_SEL_BIT      14
`define M8X_X_HI         10
`define M8X_X_LO         8
`define M8X_Y_HI         7
`define M8X_Y_LO         5
`define M8X_K_HI         7
`define M8X_K_LO         0
`define M8X_IE_BIT       0

// ----------------------------------------------------------------
// opcode codes, bit 14 masked out (it picks constant or register), except the interrupt enable and disable codes, which bit 14 tells apart
// ----------------------------------------------------------------
`define M8X_OPC_LOAD     5'h00
`define M8X_OPC_AND      5'h01
`define M8X_OPC_OR       5'h02
`define M8X_OPC_XOR      5'h03
`define M8X_OPC_ADD      5'h04
`define M8X_OPC_ADDC     5'h05
`define M8X_OPC_SUB      5'h06
`define M8X_OPC_SUBC     5'h07
// or into an opcode to take the second operand or port address from a register
`define M8X_OPC_REG      5'h08
`define M8X_OPC_IN       5'h10
`define M8X_OPC_OUT      5'h11
`define M8X_OPC_IRET     5'h12
`define M8X_OPC_INTEN    5'h1E
`define M8X_OPC_INTDIS   5'h16

// ----------------------------------------------------------------
// reset values and vectors
// ----------------------------------------------------------------
`define M8X_PC_RESET     8'h00
`define M8X_INT_VECTOR   8'hFF
`define M8X_STACK_DEPTH  4

`endif

// [rtl/m8x_alu.v]
// combinational alu for logical and arithmetic groups
`timescale 1ns/100ps
`include "m8x_defs.vh"

module m8x_alu (
  input  wire [4:0] op,
  input  wire [7:0] a,
  input  wire [7:0] b,
  input  wire       carry_in,
  output reg  [7:0] result,
  output reg        carry_out,
  output reg        flags_we
);

  reg [8:0] wide;

  always @* begin
    wide      = 9'h000;
    result    = a;
    carry_out = carry_in;
    flags_we  = 1'b0;
    case (op)
      `M8X_OPC_LOAD: begin
        result = b;  // see [RULE1]
      end
      `M8X_OPC_AND: begin
        result    = a & b;  // see [RULE3]
        carry_out = 1'b0;   // see [RULE23]
        flags_we  = 1'b1;
      end
      `M8X_OPC_OR: begin
        result    = a | b;  // see [RULE4] see [RULE5]
        carry_out = 1'b0;   // see [RULE23]
        flags_we  = 1'b1;
      end
      `M8X_OPC_XOR: begin
        result    = a ^ b;
        carry_out = 1'b0;   // see [RULE6]
        flags_we  = 1'b1;
      end
      `M8X_OPC_ADD: begin
        wide      = {1'b0, a} + {1'b0, b};  // see [RULE7]
        result    = wide[7:0];
        carry_out = wide[8];                // see [RULE22]
        flags_we  = 1'b1;
      end
      `M8X_OPC_ADDC: begin
        wide      = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};  // see [RULE8]
        result    = wide[7:0];
        carry_out = wide[8];
        flags_we  = 1'b1;
      end
      `M8X_OPC_SUB: begin
        wide      = {1'b0, a} - {1'b0, b};  // see [RULE9]
        result    = wide[7:0];
        carry_out = wide[8];                // borrow, see [RULE22]
        flags_we  = 1'b1;
      end
      `M8X_OPC_SUBC: begin
        wide      = {1'b0, a} - {1'b0, b} - {8'h00, carry_in};  // see [RULE10]
        result    = wide[7:0];
        carry_out = wide[8];
        flags_we  = 1'b1;
      end
      default: begin
        result = a;
      end
    endcase
  end

endmodule

// [rtl/m8x_core.v]
// execute core: registers, flags, port strobes, interrupt entry and return
`timescale 1ns/100ps
`include "m8x_defs.vh"

module m8x_core (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire [15:0] instr,
  input  wire [7:0]  in_port,
  input  wire        interrupt,
  output reg  [7:0]  pc_q,
  output reg  [7:0]  port_id_q,
  output reg  [7:0]  out_port_q,
  output reg         read_strobe_q,
  output reg         write_strobe_q,
  output reg         zero_q,
  output reg         carry_q,
  output reg         int_en_q,
  output reg         phase_q
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [7:0]  regs_q [0:7];
  reg [7:0]  stack_q [0:`M8X_STACK_DEPTH-1];
  reg [1:0]  sp_q;
  reg [15:0] ir_q;
  reg        saved_zero_q;
  reg        saved_carry_q;
  reg        int_pend_q;

  wire [4:0] opc    = {ir_q[15], 1'b0, ir_q[13:11]};
  wire       use_reg = ir_q[`M8X_SEL_BIT];
  wire [2:0] rx     = ir_q[`M8X_X_HI:`M8X_X_LO];
  wire [2:0] ry     = ir_q[`M8X_Y_HI:`M8X_Y_LO];
  wire [7:0] opa    = regs_q[rx];
  wire [7:0] opb    = use_reg ? regs_q[ry] : ir_q[`M8X_K_HI:`M8X_K_LO];
  wire [7:0] alu_res;
  wire       alu_c;
  wire       alu_fwe;
  wire [1:0] sp_dec = sp_q - 2'h1;
  wire       take_int = interrupt & int_en_q;

  // decode of the whole opcode field, used for the interrupt enable and disable checks
  function is_op;
    input [15:0] word;
    input [4:0]  code;
    begin
      is_op = (word[`M8X_OP_HI:`M8X_OP_LO] == code);
    end
  endfunction

  m8x_alu u_alu (
    .op        (opc),
    .a         (opa),
    .b         (opb),
    .carry_in  (carry_q),
    .result    (alu_res),
    .carry_out (alu_c),
    .flags_we  (alu_fwe)
  );

  // ----------------------------------------------------------------
  // two-phase sequencer: fetch/decode, then execute
  // ----------------------------------------------------------------
  integer i;
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      phase_q        <= 1'b0;
      pc_q           <= `M8X_PC_RESET;
      ir_q           <= 16'h0000;
      sp_q           <= 2'h0;
      zero_q         <= 1'b0;
      carry_q        <= 1'b0;
      int_en_q       <= 1'b0;
      saved_zero_q   <= 1'b0;
      saved_carry_q  <= 1'b0;
      int_pend_q     <= 1'b0;
      port_id_q      <= 8'h00;
      out_port_q     <= 8'h00;
      read_strobe_q  <= 1'b0;
      write_strobe_q <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        regs_q[i] <= 8'h00;
      end
      for (i = 0; i < `M8X_STACK_DEPTH; i = i + 1) begin
        stack_q[i] <= 8'h00;
      end
    end else begin
      read_strobe_q  <= 1'b0;
      write_strobe_q <= 1'b0;
      phase_q        <= ~phase_q;  // see [RULE20]
      if (!phase_q) begin
        // first cycle: latch instruction, present port address early
        ir_q       <= instr;
        int_pend_q <= take_int;
        port_id_q  <= instr[`M8X_SEL_BIT] ? regs_q[instr[`M8X_Y_HI:`M8X_Y_LO]] : instr[7:0];  // see [RULE14]
        out_port_q <= regs_q[instr[`M8X_X_HI:`M8X_X_LO]];
        // no strobe for an instruction the interrupt replaces: it reruns, and the port must see it once
        if (instr[15] && instr[13:11] == 3'h0 && !take_int) begin
          read_strobe_q <= 1'b1;  // see [RULE13]
        end
        if (instr[15] && instr[13:11] == 3'h1 && !take_int) begin
          write_strobe_q <= 1'b1;  // see [RULE15]
        end
      end else if (int_pend_q) begin
        // interrupt replaces this execute: call ff, instruction rerun later
        stack_q[sp_q] <= pc_q;
        sp_q          <= sp_q + 2'h1;
        pc_q          <= `M8X_INT_VECTOR;  // see [RULE21]
        saved_zero_q  <= zero_q;
        saved_carry_q <= carry_q;
        int_en_q      <= 1'b0;
      end else begin
        pc_q <= pc_q + 8'h01;
        if (is_op(ir_q, `M8X_OPC_INTEN)) begin
          int_en_q <= 1'b1;  // see [RULE19]
        end else if (is_op(ir_q, `M8X_OPC_INTDIS)) begin
          int_en_q <= 1'b0;  // see [RULE19]
        end else if (opc == `M8X_OPC_IRET) begin
          pc_q     <= stack_q[sp_dec];  // see [RULE16]
          sp_q     <= sp_dec;
          zero_q   <= saved_zero_q;     // see [RULE17]
          carry_q  <= saved_carry_q;
          int_en_q <= ir_q[`M8X_IE_BIT];  // see [RULE18]
        end else if (opc == `M8X_OPC_IN) begin
          regs_q[rx] <= in_port;  // see [RULE11] see [RULE12]
        end else if (!ir_q[15]) begin
          // load reg_zero from itself rewrites the same value, see [RULE2]
          regs_q[rx] <= alu_res;
          if (alu_fwe) begin
            zero_q  <= (alu_res == 8'h00);  // see [RULE22]
            carry_q <= alu_c;
          end
        end
      end
    end
  end

endmodule

// [testbench/m8x_asserts.sv]
// port assertions for the execute core
`timescale 1ns/100ps
`include "m8x_defs.vh"
module m8x_asserts (
  input wire        ref_clk,
  input wire        rst_n,
  input wire [15:0] instr,
  input wire        interrupt,
  input wire [7:0]  pc_q,
  input wire        read_strobe_q,
  input wire        write_strobe_q,
  input wire        zero_q,
  input wire        carry_q,
  input wire        int_en_q,
  input wire        phase_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // an accepted interrupt replaces the fetched instruction
  wire       tk = !phase_q && interrupt && int_en_q;
  wire       go = !phase_q && !tk;
  wire [4:0] op = instr[15:11];
  AST_PHASE:
    assert property (!phase_q |=> phase_q) else $error("no execute cycle");
  AST_FETCH:
    assert property (phase_q |=> !phase_q) else $error("no fetch cycle");
  AST_PC_HOLD:
    assert property (!phase_q |=> $stable(pc_q)) else $error("pc moved early");
  AST_RD:
    assert property (go && op == `M8X_OPC_IN |=> read_strobe_q ##1 !read_strobe_q) else $error("read strobe");
  AST_WR:
    assert property (go && op == `M8X_OPC_OUT |=> write_strobe_q ##1 !write_strobe_q) else $error("write strobe");
  AST_NO_STROBE_INT:
    assert property (tk |=> !read_strobe_q && !write_strobe_q) else $error("strobe for replaced instruction");
  AST_IO_FLAGS:
    assert property (read_strobe_q || write_strobe_q |=> $stable({zero_q, carry_q})) else $error("io flags");
  AST_INT:
    assert property (tk |-> ##2 (pc_q == `M8X_INT_VECTOR && !int_en_q)) else $error("interrupt entry");
  AST_IEN:
    assert property (go && op == `M8X_OPC_INTEN |-> ##2 int_en_q) else $error("enable");
  AST_IDIS:
    assert property (go && op == `M8X_OPC_INTDIS |-> ##2 !int_en_q) else $error("disable");
  AST_IRET:
    assert property (go && op == `M8X_OPC_IRET |-> ##2 int_en_q == $past(instr[0], 2)) else $error("iret enable");
  cover property (tk);
  cover property (go && op == `M8X_OPC_IRET);
  cover property (read_strobe_q);
  cover property (write_strobe_q);
endmodule
bind m8x_core m8x_asserts m8x_asserts_u (
  .ref_clk        (ref_clk),
  .rst_n          (rst_n),
  .instr          (instr),
  .interrupt      (interrupt),
  .pc_q           (pc_q),
  .read_strobe_q  (read_strobe_q),
  .write_strobe_q (write_strobe_q),
  .zero_q         (zero_q),
  .carry_q        (carry_q),
  .int_en_q       (int_en_q),
  .phase_q        (phase_q)
);

// [testbench/m8x_port_model.sv]
// user port decode logic facing the core
`timescale 1ns/100ps
module m8x_port_model (
  input  wire       ref_clk,
  input  wire [7:0] port_id_q,
  input  wire [7:0] out_port_q,
  input  wire       write_strobe_q,
  output wire [7:0] in_port,
  output reg  [7:0] cap_q
);
  // every port answers with its inverted address
  assign in_port = ~port_id_q;
  initial cap_q = 8'h00;
  always @(posedge ref_clk) begin
    if (write_strobe_q) begin
      cap_q <= out_port_q;
    end
  end
endmodule

// [testbench/micro8_alu_io_execute_tb.sv]
// self-checking bench for the execute core
`timescale 1ns/100ps
`include "m8x_defs.vh"
module micro8_alu_io_execute_tb;
  reg         ref_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [15:0] instr = 16'h0000;
  reg         interrupt = 1'b0;
  wire [7:0]  pc_q, port_id_q, out_port_q, in_port, cap_q;
  wire        read_strobe_q, write_strobe_q, zero_q, carry_q, int_en_q, phase_q;
  integer     num_errors = 0;
  integer     checks_done = 0;
  integer     cycles = 0;
  reg  [7:0]  p;
  always #50 ref_clk = ~ref_clk;
  m8x_core dut_u (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .instr          (instr),
    .in_port        (in_port),
    .interrupt      (interrupt),
    .pc_q           (pc_q),
    .port_id_q      (port_id_q),
    .out_port_q     (out_port_q),
    .read_strobe_q  (read_strobe_q),
    .write_strobe_q (write_strobe_q),
    .zero_q         (zero_q),
    .carry_q        (carry_q),
    .int_en_q       (int_en_q),
    .phase_q        (phase_q)
  );
  m8x_port_model port_u (
    .ref_clk        (ref_clk),
    .port_id_q      (port_id_q),
    .out_port_q     (out_port_q),
    .write_strobe_q (write_strobe_q),
    .in_port        (in_port),
    .cap_q          (cap_q)
  );
  task test_done;
    begin
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) begin
        $display("Test passed");
      end else begin
        $display("Test failed");
      end
      $finish;
    end
  endtask
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("unexpected value at %0t: %h not %h", $time, seen, exp);
      end
    end
  endtask
  task run(input [15:0] w);
    begin
      chk(phase_q, 8'h00);
      instr = w;
      repeat (2) @(posedge ref_clk);
      #1;
    end
  endtask
  // register one is read back by an output to port C3
  task see(input [7:0] r, input [1:0] fl);
    begin
      run({`M8X_OPC_OUT, 3'h1, 8'hC3});
      chk(port_id_q, 8'hC3);
      chk(cap_q, r);
      chk({zero_q, carry_q}, fl);
    end
  endtask
  task alu(input [4:0] op, input [7:0] k, input [7:0] r, input [1:0] fl);
    begin
      run({op, 3'h1, k});
      see(r, fl);
    end
  endtask
  task t_arith;
    begin
      alu(`M8X_OPC_LOAD, 8'hFF, 8'hFF, 2'h0);
      alu(`M8X_OPC_ADD, 8'h01, 8'h00, 2'h3);
      alu(`M8X_OPC_ADDC, 8'h00, 8'h01, 2'h0);
      alu(`M8X_OPC_SUB, 8'h02, 8'hFF, 2'h1);
      alu(`M8X_OPC_LOAD, 8'h0F, 8'h0F, 2'h1);
      alu(`M8X_OPC_SUBC, 8'h0E, 8'h00, 2'h2);
    end
  endtask
  task t_logic;
    begin
      alu(`M8X_OPC_ADD, 8'hF0, 8'hF0, 2'h0);
      alu(`M8X_OPC_ADD, 8'h10, 8'h00, 2'h3);
      alu(`M8X_OPC_OR, 8'h00, 8'h00, 2'h2);
      alu(`M8X_OPC_ADD, 8'hFF, 8'hFF, 2'h0);
      alu(`M8X_OPC_ADD, 8'h01, 8'h00, 2'h3);
      alu(`M8X_OPC_XOR, 8'h3C, 8'h3C, 2'h0);
      alu(`M8X_OPC_OR, 8'h03, 8'h3F, 2'h0);
      alu(`M8X_OPC_ADD, 8'hC1, 8'h00, 2'h3);
      alu(`M8X_OPC_LOAD, 8'h0F, 8'h0F, 2'h3);
      alu(`M8X_OPC_AND, 8'h33, 8'h03, 2'h0);
    end
  endtask
  task t_io;
    begin
      alu(`M8X_OPC_ADD, 8'hFD, 8'h00, 2'h3);
      run({`M8X_OPC_IN, 3'h1, 8'h5A});
      chk(port_id_q, 8'h5A);
      see(8'hA5, 2'h3);
    end
  endtask
  task t_int;
    begin
      run({`M8X_OPC_INTEN, 11'h000});
      chk(int_en_q, 8'h01);
      p = pc_q;
      interrupt = 1'b1;
      run({`M8X_OPC_XOR, 3'h1, 8'hFF});
      interrupt = 1'b0;
      chk(pc_q, `M8X_INT_VECTOR);
      chk(int_en_q, 8'h00);
      alu(`M8X_OPC_ADD, 8'h01, 8'hA6, 2'h0);
      run({`M8X_OPC_IRET, 11'h001});
      chk(pc_q, p);
      chk({zero_q, carry_q}, 8'h03);
      chk(int_en_q, 8'h01);
      run({`M8X_OPC_INTDIS, 11'h000});
      chk(int_en_q, 8'h00);
      // reg_zero gets a nonzero value so that the no-operation has something to disturb
      run({`M8X_OPC_LOAD, 3'h0, 8'h5A});
      // a masked interrupt must not disturb the no-operation
      interrupt = 1'b1;
      p = pc_q;
      run(16'h4000);
      interrupt = 1'b0;
      chk(pc_q, p + 8'h01);
      see(8'hA6, 2'h3);
      run({`M8X_OPC_OUT, 3'h0, 8'hC3});
      chk(cap_q, 8'h5A);
    end
  endtask
  // register operands: second operand and port address come from reg_zero
  task t_reg;
    begin
      run({`M8X_OPC_SUB | `M8X_OPC_REG, 3'h1, 3'h0, 5'h00});
      see(8'h4C, 2'h0);
      run({`M8X_OPC_OUT | `M8X_OPC_REG, 3'h1, 3'h0, 5'h00});
      chk(port_id_q, 8'h5A);
      chk(cap_q, 8'h4C);
      run({`M8X_OPC_IN | `M8X_OPC_REG, 3'h1, 3'h0, 5'h00});
      chk(port_id_q, 8'h5A);
      chk(cap_q, 8'h4C);
      see(8'hA5, 2'h0);
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_arith;
    t_logic;
    t_io;
    t_int;
    t_reg;
    test_done;
  end
endmodule
